// file: logic/sgl_map.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the serial control block. Included by bare name; no logic here.
 */
`ifndef SGL_MAP_SVH
`define SGL_MAP_SVH

// ==========================================================
// Register byte offsets
`define SGL_OFF_GCR1 8'h04
`define SGL_OFF_INT0 8'h08
`define SGL_OFF_FLG 8'h10
`define SGL_OFF_PC0 8'h14
`define SGL_OFF_DAT0 8'h38
`define SGL_OFF_DAT1 8'h3C
`define SGL_OFF_BUF 8'h40

// ==========================================================
// Field positions
`define SGL_BIT_ENABLE 24
`define SGL_BIT_ECHO 16
`define SGL_BIT_LOWPOW 8
`define SGL_BIT_DMA 16
`define SGL_BIT_OVRN 6
`define SGL_BIT_RXFULL 8
`define SGL_BIT_TXRDY 9
`define SGL_BIT_BUF_EMPTY 31
`define SGL_BIT_BUF_OVRN 30

// ==========================================================
// Encodings and reset values
`define SGL_MODE_SLAVE 2'h0
`define SGL_MODE_MASTER 2'h3
`define SGL_RST_MODE 2'h0
`define SGL_RST_BIT 1'h0
`define SGL_RST_RECEIVE_EMPTY_FLAG 1'h1
`define SGL_BIT_CNT_LAST 3'h7

// ==========================================================
// Timing: serial clock half period
// The half period must outlast the four-edge delay of the pin
// synchroniser, or a master samples the incoming line one bit late.
`define SGL_CLK_NS 100
`define SGL_SCLK_HALF_NS 800
`define SGL_SCLK_HALF_CYC (`SGL_SCLK_HALF_NS / `SGL_CLK_NS)

`endif

// file: logic/sgl_pkg.sv
/*
 * Types shared by the serial control block.
 * Assumes the constants of sgl_map.svh are used alongside.
 */
package sgl_pkg;
	typedef logic [7:0] sgl_word_t;
	typedef enum logic [3:0] {
		sgl_st_off = 4'h1,
		sgl_st_idle = 4'h2,
		sgl_st_shift = 4'h4,
		sgl_st_pdown = 4'h8
	} sgl_state_t;
endpackage

// file: logic/sgl_eng_if.sv
/*
 * Carrier between the control top and the serial engine.
 * Assumes both ends run on the one system clock.
 */
`timescale 1ns/1ps
interface sgl_eng_if;
	logic enable;
	logic echo;
	logic lowpow;
	logic master;
	logic start;
	sgl_pkg::sgl_word_t tx_word;
	logic sclk_s;
	logic mosi_s;
	logic miso_s;
	logic accept;
	logic done;
	logic busy;
	logic powered_down;
	sgl_pkg::sgl_word_t rx_word;
	logic sclk_drv;
	logic data_drv;
	modport ctrl(output enable, echo, lowpow, master, start, tx_word,
		sclk_s, mosi_s, miso_s,
		input accept, done, busy, powered_down, rx_word, sclk_drv,
		data_drv);
	modport eng(input enable, echo, lowpow, master, start, tx_word,
		sclk_s, mosi_s, miso_s,
		output accept, done, busy, powered_down, rx_word, sclk_drv,
		data_drv);
endinterface

// file: logic/sgl_pin_sync.sv
/*
 * Three-stage synchroniser for pin inputs, one chain per bit.
 * Assumes inputs are asynchronous to clk_sys_in.
 */
`timescale 1ns/1ps
module sgl_pin_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Pins and settled levels
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge clk_sys_in) begin
				if (reset_in) begin
					s1 <= 1'h0;
					s2 <= 1'h0;
					s3 <= 1'h0;
					q_out[i] <= 1'h0;
				end else begin
					s1 <= d_in[i];
					s2 <= s1;
					s3 <= s2;
					// A change counts only once two stages agree.
					if (s2 == s3) begin
						q_out[i] <= s3;
					end
				end
			end
		end
	endgenerate
endmodule

// file: logic/sgl_engine.sv
/*
 * Serial shift engine: one 8-bit character per start, mode 0 timing.
 * Assumes pin levels arrive already synchronised through the carrier.
 */
`timescale 1ns/1ps
`include "sgl_map.svh"
module sgl_engine (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Control carrier
	sgl_eng_if.eng eng
);
	sgl_pkg::sgl_state_t state;
	sgl_pkg::sgl_word_t tx_shift;
	sgl_pkg::sgl_word_t rx_shift;
	sgl_pkg::sgl_word_t holding;
	logic [2:0] div_cnt;
	logic [2:0] bit_cnt;
	logic phase;
	logic sclk_prev;
	logic done;
	logic tick;
	logic rise;
	logic fall;
	logic last_edge;
	logic rx_bit;

	// ==========================================================
	// Edge generation
	assign tick = eng.master && state == sgl_pkg::sgl_st_shift &&
		div_cnt == 3'(`SGL_SCLK_HALF_CYC - 1);
	assign rise = eng.master ? (tick && !phase) : (eng.sclk_s && !sclk_prev);
	assign fall = eng.master ? (tick && phase) : (!eng.sclk_s && sclk_prev);
	assign last_edge = state == sgl_pkg::sgl_st_shift && fall &&
		bit_cnt == `SGL_BIT_CNT_LAST;
	// In echo mode the incoming bit is taken from the outgoing bit.
	assign rx_bit = eng.echo ? tx_shift[7] :
		(eng.master ? eng.miso_s : eng.mosi_s);

	always_ff @(posedge clk_sys_in) begin
		if (reset_in || state != sgl_pkg::sgl_st_shift) begin
			div_cnt <= 3'h0;
			phase <= 1'h0;
		end else if (tick) begin
			div_cnt <= 3'h0;
			phase <= !phase;
		end else begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sclk_prev <= 1'h0;
		end else begin
			sclk_prev <= eng.sclk_s;
		end
	end

	// ==========================================================
	// State machine
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !eng.enable) begin
			state <= sgl_pkg::sgl_st_off;
		end else begin
			case (state)
				sgl_pkg::sgl_st_off: state <= sgl_pkg::sgl_st_idle;
				sgl_pkg::sgl_st_idle: begin
					if (eng.lowpow) begin
						state <= sgl_pkg::sgl_st_pdown;
					end else if (eng.start) begin
						state <= sgl_pkg::sgl_st_shift;
					end
				end
				sgl_pkg::sgl_st_shift: begin
					if (last_edge) begin
						state <= sgl_pkg::sgl_st_idle;
					end
				end
				sgl_pkg::sgl_st_pdown: begin
					if (!eng.lowpow) begin
						state <= sgl_pkg::sgl_st_idle;
					end
				end
				default: state <= sgl_pkg::sgl_st_off;
			endcase
		end
	end

	// ==========================================================
	// Shift registers and holding word, all zeroed while inactive
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !eng.enable) begin
			tx_shift <= 8'h00;
			rx_shift <= 8'h00;
			bit_cnt <= 3'h0;
		end else if (eng.accept) begin
			tx_shift <= eng.tx_word;
			bit_cnt <= 3'h0;
		end else if (state == sgl_pkg::sgl_st_shift) begin
			if (rise) begin
				rx_shift <= {rx_shift[6:0], rx_bit};
			end
			if (fall) begin
				tx_shift <= {tx_shift[6:0], 1'h0};
				bit_cnt <= bit_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !eng.enable) begin
			holding <= 8'h00;
			done <= 1'h0;
		end else begin
			done <= last_edge;
			if (last_edge) begin
				holding <= rx_shift;
			end
		end
	end

	assign eng.accept = state == sgl_pkg::sgl_st_idle && eng.start &&
		!eng.lowpow;
	assign eng.done = done;
	assign eng.busy = state == sgl_pkg::sgl_st_shift;
	assign eng.powered_down = state == sgl_pkg::sgl_st_pdown;
	assign eng.rx_word = holding;
	assign eng.sclk_drv = phase;
	assign eng.data_drv = tx_shift[7];

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	a_echo_bit_loop: assert property (
		(eng.echo && eng.busy && rise) |=> rx_shift[0] == $past(tx_shift[7]))
		else $error("echo bit not looped back");
	a_lowpow_enter: assert property (
		(eng.enable && eng.lowpow && state == sgl_pkg::sgl_st_idle) |=>
		state == sgl_pkg::sgl_st_pdown || !eng.enable)
		else $error("power-down state not entered");
	a_off_regs_zero: assert property (
		!eng.enable |=> tx_shift == 8'h00 && rx_shift == 8'h00 &&
		holding == 8'h00)
		else $error("shift registers not cleared");
	c_pdown_seen: cover property (state == sgl_pkg::sgl_st_pdown);
endmodule

// file: logic/sgl_top.sv
/*
 * Serial peripheral control top: APB slave with the global control,
 * DMA gate, flag, pin function, transmit and receive registers, and
 * the pin gating for echo self-test.
 * Assumes an APB3 master on clk_sys_in and pins synchronised here.
 */
// Decided for this implementation: the APB register port and the address map.
// Overview of operation
// - Transfers run only while the enable bit 24 is one.
// - DMA requests appear only after enable; set the gate after enabling.
// - Dropping enable zeroes shifters, transmit words, flags, buffers.
// - The receive-empty indicator returns to one, not zero, on disable.
// - Echo bit 16 with both data pins functional loops output to input.
// - In echo mode clock pin drives inactive, data pins float.
// - Power-down bit 8 sends the engine to its power-down state.
// - Reserved bits 31-25, 23-17, 15-9, 7-2 read zero, ignore writes.
// - Mode field zero is slave, three is master driving the clock.
`timescale 1ns/1ps
`include "sgl_map.svh"
module sgl_top (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// DMA requests
	output logic dma_rx_req_out,
	output logic dma_tx_req_out,
	// Serial clock pin
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_out,
	// Master-out data pin
	input wire logic master_out_line_in,
	output logic master_out_line_out,
	output logic master_out_line_oe_out,
	// Master-in data pin
	input wire logic master_in_line_in,
	output logic master_in_line_out,
	output logic master_in_line_oe_out
);
	sgl_eng_if eng();

	logic enable;
	logic echo;
	logic lowpow;
	logic [1:0] mode;
	logic dma_gate;
	logic [2:0] pin_func;
	sgl_pkg::sgl_word_t tx_a;
	sgl_pkg::sgl_word_t tx_b;
	logic tx_sel;
	logic tx_pend;
	sgl_pkg::sgl_word_t buf_data;
	logic rx_full;
	logic overrun;
	logic buf_fresh;
	logic [2:0] pins_s;
	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic hit;
	logic [31:0] rd_word;
	logic [31:0] gcr1_word;
	logic [31:0] buf_word;
	logic master;
	logic slave;
	logic echo_act;
	logic buf_clear;

	// ==========================================================
	// Pin synchronisers and engine
	sgl_pin_sync #(.W(3)) u_sync (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.d_in({serial_clock_pin_in, master_out_line_in, master_in_line_in}),
		.q_out(pins_s)
	);

	sgl_engine u_engine (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.eng(eng)
	);

	assign master = mode == `SGL_MODE_MASTER;
	assign slave = mode == `SGL_MODE_SLAVE;
	// Echo needs both data pins in serial function; software owns the
	// master-mode precondition, so slave-mode echo is not policed.
	assign echo_act = echo && pin_func[0] && pin_func[1];

	assign eng.enable = enable;
	assign eng.echo = echo_act;
	assign eng.lowpow = lowpow;
	assign eng.master = master;
	assign eng.start = tx_pend;
	assign eng.tx_word = tx_sel ? tx_b : tx_a;
	assign eng.sclk_s = pins_s[2];
	assign eng.mosi_s = pins_s[1];
	assign eng.miso_s = pins_s[0];

	// ==========================================================
	// Pin drive
	assign serial_clock_pin_oe_out = enable && master && pin_func[2];
	assign serial_clock_pin_out = echo_act ? 1'h0 : eng.sclk_drv;
	assign master_out_line_oe_out = enable && master && pin_func[0] &&
		!echo_act;
	assign master_out_line_out = eng.data_drv;
	assign master_in_line_oe_out = enable && slave && pin_func[1] &&
		!echo_act;
	assign master_in_line_out = eng.data_drv;

	// ==========================================================
	// APB decode
	assign setup = psel_in && !penable_in;
	assign access = psel_in && penable_in;
	assign wr = access && pwrite_in;
	assign rd = access && !pwrite_in;
	assign pready_out = penable_in;

	assign gcr1_word = {7'h00, enable, 7'h00, echo, 7'h00, lowpow,
		6'h00, mode};
	// Empty reads as the inverse of full, so it is one while inactive.
	assign buf_word = {!rx_full, overrun, 22'h000000, buf_data};

	always_comb begin
		hit = 1'h1;
		rd_word = 32'h00000000;
		if (paddr_in == `SGL_OFF_GCR1) begin
			rd_word = gcr1_word;
		end else if (paddr_in == `SGL_OFF_INT0) begin
			rd_word[`SGL_BIT_DMA] = dma_gate;
		end else if (paddr_in == `SGL_OFF_FLG) begin
			rd_word[`SGL_BIT_OVRN] = overrun;
			rd_word[`SGL_BIT_RXFULL] = rx_full;
			rd_word[`SGL_BIT_TXRDY] = enable && !tx_pend;
		end else if (paddr_in == `SGL_OFF_PC0) begin
			rd_word[2:0] = pin_func;
		end else if (paddr_in == `SGL_OFF_DAT0) begin
			rd_word[7:0] = tx_a;
		end else if (paddr_in == `SGL_OFF_DAT1) begin
			rd_word[7:0] = tx_b;
		end else if (paddr_in == `SGL_OFF_BUF) begin
			rd_word = buf_word;
		end else begin
			hit = 1'h0;
		end
	end

	assign pslverr_out = access && !hit;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			prdata_out <= 32'h00000000;
		end else if (setup && !pwrite_in) begin
			prdata_out <= rd_word;
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			enable <= `SGL_RST_BIT;
			echo <= `SGL_RST_BIT;
			lowpow <= `SGL_RST_BIT;
			mode <= `SGL_RST_MODE;
		end else if (wr && paddr_in == `SGL_OFF_GCR1) begin
			// Only the named fields load; reserved ranges are dropped.
			enable <= pwdata_in[`SGL_BIT_ENABLE];
			echo <= pwdata_in[`SGL_BIT_ECHO];
			lowpow <= pwdata_in[`SGL_BIT_LOWPOW];
			mode <= pwdata_in[1:0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			dma_gate <= `SGL_RST_BIT;
			pin_func <= 3'h0;
		end else if (wr && paddr_in == `SGL_OFF_INT0) begin
			dma_gate <= pwdata_in[`SGL_BIT_DMA];
		end else if (wr && paddr_in == `SGL_OFF_PC0) begin
			pin_func <= pwdata_in[2:0];
		end
	end

	// ==========================================================
	// Transmit words; held at zero while inactive
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !enable) begin
			tx_a <= 8'h00;
			tx_b <= 8'h00;
			tx_sel <= 1'h0;
		end else if (wr && paddr_in == `SGL_OFF_DAT0) begin
			tx_a <= pwdata_in[7:0];
			tx_sel <= 1'h0;
		end else if (wr && paddr_in == `SGL_OFF_DAT1) begin
			tx_b <= pwdata_in[7:0];
			tx_sel <= 1'h1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !enable) begin
			tx_pend <= 1'h0;
		end else if (wr && (paddr_in == `SGL_OFF_DAT0 ||
			paddr_in == `SGL_OFF_DAT1)) begin
			tx_pend <= 1'h1;
		end else if (eng.accept) begin
			tx_pend <= 1'h0;
		end
	end

	// ==========================================================
	// Receive buffer; reading it clears full and overrun
	// A read only clears what it actually returned, so a character that
	// lands between setup and access is kept for the next read.
	assign buf_clear = rd && paddr_in == `SGL_OFF_BUF && !buf_fresh;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !enable) begin
			buf_fresh <= 1'h0;
		end else if (eng.done) begin
			buf_fresh <= 1'h1;
		end else if (setup) begin
			buf_fresh <= 1'h0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !enable) begin
			buf_data <= 8'h00;
			rx_full <= 1'h0;
			overrun <= 1'h0;
		end else if (eng.done) begin
			buf_data <= eng.rx_word;
			rx_full <= 1'h1;
			overrun <= overrun || (rx_full && !buf_clear);
		end else if (buf_clear) begin
			rx_full <= 1'h0;
			overrun <= 1'h0;
		end
	end

	// ==========================================================
	// DMA requests, only while enabled and gated
	assign dma_rx_req_out = dma_gate && enable && rx_full;
	assign dma_tx_req_out = dma_gate && enable && !tx_pend && !lowpow;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	a_off_no_shift: assert property (!enable |=> !eng.busy)
		else $error("transfer active while disabled");
	a_accept_needs_en: assert property (eng.accept |-> enable)
		else $error("character accepted while disabled");
	a_disable_clears: assert property ($fell(enable) |=>
		tx_a == 8'h00 && tx_b == 8'h00 && buf_data == 8'h00 && !overrun)
		else $error("state not cleared on disable");
	a_empty_default: assert property (!enable |=>
		buf_word == 32'h800000FF - 32'h000000FF)
		else $error("receive word not at default");
	a_echo_pins_quiet: assert property ((echo_act && enable) |->
		!master_out_line_oe_out && !master_in_line_oe_out &&
		!serial_clock_pin_out)
		else $error("pins active in echo mode");
	a_gcr1_reserved: assert property ((rd && paddr_in == `SGL_OFF_GCR1 &&
		$past(setup)) |-> prdata_out[31:25] == 7'h00 &&
		prdata_out[23:17] == 7'h00 && prdata_out[15:9] == 7'h00 &&
		prdata_out[7:2] == 6'h00)
		else $error("reserved bits read nonzero");
	a_reset_clear: assert property (
		$past(reset_in) |-> !enable && !echo && !lowpow)
		else $error("control bits not zero after reset");
	a_clock_master: assert property (
		serial_clock_pin_oe_out |-> mode == `SGL_MODE_MASTER)
		else $error("clock driven outside master mode");
	a_dma_after_en: assert property (
		(dma_rx_req_out || dma_tx_req_out) |-> enable && dma_gate)
		else $error("DMA request without enable");
	a_done_fills: assert property (eng.done |=> rx_full)
		else $error("received character not flagged");

	c_master_char: cover property (eng.done && master && !echo_act);
	c_echo_char: cover property (eng.done && echo_act);
	c_disable: cover property ($fell(enable) && rx_full);
	c_overrun: cover property ($rose(overrun));
endmodule

// file: sim/sgl_peer.sv
/*
 * Behavioural external serial slave, clock mode 0, MSB first.
 * Assumes the block is master and the clock line idles low.
 */
`timescale 1ns/1ps
module sgl_peer (
	// Serial pins
	input wire logic sclk_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe_out,
	// Bench side
	input wire logic sel_in,
	input wire logic [7:0] tx_byte_in,
	output logic [7:0] rx_byte_out
);
	logic [7:0] shreg;
	initial begin
		shreg = 8'h00;
		rx_byte_out = 8'h00;
	end
	// Unselected, the line is released and the pull-up takes it high.
	assign miso_oe_out = sel_in;
	assign miso_out = shreg[7];
	always @(posedge sel_in) begin
		shreg = tx_byte_in;
	end
	always @(posedge sclk_in) begin
		rx_byte_out = {rx_byte_out[6:0], mosi_in};
	end
	always @(negedge sclk_in) begin
		if (sel_in) begin
			shreg = {shreg[6:0], 1'b0};
		end
	end
endmodule

// file: sim/sgl_tb.sv
/*
 * Self-checking bench of the serial control top over APB.
 * Assumes zero-wait APB answers and pull-ups on both data lines.
 */
`timescale 1ns/1ps
`include "sgl_map.svh"
module tb;
	logic clk, rst, psel, pen, pwr, rdy, serr, er, dma_rx, dma_tx;
	logic [7:0] paddr, p_tx, p_rx;
	logic [31:0] pwdata, prdata, rd, seed;
	logic ck_o, ck_oe, mo_o, mo_oe, mi_o, mi_oe, p_o, p_oe, p_sel;
	int errors, checks_done;
	wire ck_w = ck_oe ? ck_o : 1'b0;
	wire mo_w = mo_oe ? mo_o : 1'b1;
	wire mi_w = mi_oe ? mi_o : (p_oe ? p_o : 1'b1);
	sgl_top uut (.clk_sys_in(clk), .reset_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(rdy),
		.pslverr_out(serr), .dma_rx_req_out(dma_rx),
		.dma_tx_req_out(dma_tx), .serial_clock_pin_in(ck_w),
		.serial_clock_pin_out(ck_o), .serial_clock_pin_oe_out(ck_oe),
		.master_out_line_in(mo_w), .master_out_line_out(mo_o),
		.master_out_line_oe_out(mo_oe), .master_in_line_in(mi_w),
		.master_in_line_out(mi_o), .master_in_line_oe_out(mi_oe));
	sgl_peer peer (.sclk_in(ck_w), .mosi_in(mo_w), .miso_out(p_o),
		.miso_oe_out(p_oe), .sel_in(p_sel), .tx_byte_in(p_tx),
		.rx_byte_out(p_rx));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] rnd(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] gcr_exp(input logic [31:0] v);
		return v & 32'h0101_0103;
	endfunction
	function automatic logic [31:0] buf_exp(input logic [7:0] b);
		return {24'h00_0000, b};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		er = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Polls the flag register until a character has landed.
	task automatic wait_full(input logic echo);
		int n;
		n = 0;
		rd = 32'h0;
		while (rd[`SGL_BIT_RXFULL] !== 1'b1 && n < 200) begin
			apb(1'b0, `SGL_OFF_FLG, 32'h0);
			if (echo) chk({29'h0, ck_w, mo_oe, mi_oe}, 32'h0);
			n++;
		end
		if (n >= 200) begin
			errors++;
		end
	endtask
	initial begin
		errors = 0;
		checks_done = 0;
		seed = 32'hA625CDFD;
		rst = 1'b1;
		{psel, pen, pwr, p_sel} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		p_tx = 8'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `SGL_OFF_GCR1, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `SGL_OFF_BUF, 32'h0);
		chk(rd, 32'h8000_0000);
		apb(1'b0, 8'h0C, 32'h0);
		chk({rd[31:1], er}, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			seed = rnd(seed);
			apb(1'b1, `SGL_OFF_GCR1, (i == 0) ? 32'hFFFF_FFFF : seed);
			apb(1'b0, `SGL_OFF_GCR1, 32'h0);
			chk(rd, gcr_exp((i == 0) ? 32'hFFFF_FFFF : seed));
		end
		apb(1'b1, `SGL_OFF_GCR1, 32'h0);
		$display("test reserved done");
		// Master mode but not enabled: nothing may move.
		apb(1'b1, `SGL_OFF_PC0, 32'h7);
		apb(1'b1, `SGL_OFF_GCR1, 32'h3);
		apb(1'b1, `SGL_OFF_DAT0, 32'h5A);
		repeat (80) @(posedge clk);
		chk({31'h0, ck_oe}, 32'h0);
		apb(1'b0, `SGL_OFF_FLG, 32'h0);
		chk(rd, 32'h0);
		$display("test disabled done");
		apb(1'b1, `SGL_OFF_GCR1, 32'h0100_0003);
		apb(1'b1, `SGL_OFF_INT0, 32'h0001_0000);
		@(negedge clk);
		chk({31'h0, dma_tx}, 32'h1);
		for (int i = 0; i < 3; i++) begin
			seed = rnd(seed);
			@(posedge clk);
			p_tx <= seed[15:8];
			p_sel <= 1'b1;
			apb(1'b1, (i == 1) ? `SGL_OFF_DAT1 : `SGL_OFF_DAT0, seed & 32'hFF);
			wait_full(1'b0);
			@(negedge clk);
			chk({31'h0, dma_rx}, 32'h1);
			apb(1'b0, `SGL_OFF_BUF, 32'h0);
			chk(rd, buf_exp(seed[15:8]));
			chk({24'h0, p_rx}, buf_exp(seed[7:0]));
			p_sel <= 1'b0;
		end
		$display("test master done");
		apb(1'b1, `SGL_OFF_GCR1, 32'h0101_0003);
		apb(1'b1, `SGL_OFF_DAT0, 32'h0);
		wait_full(1'b1);
		apb(1'b0, `SGL_OFF_BUF, 32'h0);
		chk(rd, buf_exp(8'h00));
		$display("test echo done");
		apb(1'b1, `SGL_OFF_GCR1, 32'h0100_0103);
		apb(1'b1, `SGL_OFF_DAT0, 32'h77);
		repeat (100) @(posedge clk);
		apb(1'b0, `SGL_OFF_FLG, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `SGL_OFF_GCR1, 32'h0100_0003);
		wait_full(1'b0);
		apb(1'b0, `SGL_OFF_BUF, 32'h0);
		chk(rd, buf_exp(8'hFF));
		$display("test power done");
		// Leave a character unread, then drop enable.
		apb(1'b1, `SGL_OFF_DAT0, 32'h11);
		wait_full(1'b0);
		apb(1'b1, `SGL_OFF_GCR1, 32'h0);
		@(negedge clk);
		chk({30'h0, dma_rx, dma_tx}, 32'h0);
		apb(1'b0, `SGL_OFF_FLG, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `SGL_OFF_BUF, 32'h0);
		chk(rd, 32'h8000_0000);
		apb(1'b0, `SGL_OFF_DAT0, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `SGL_OFF_GCR1, 32'h0100_0003);
		apb(1'b0, `SGL_OFF_FLG, 32'h0);
		chk(rd, 32'h200);
		apb(1'b1, `SGL_OFF_GCR1, 32'h0100_0001);
		@(negedge clk);
		chk({28'h0, ck_oe, mo_oe, mi_oe, mi_o}, 32'h0);
		apb(1'b1, `SGL_OFF_GCR1, 32'h0100_0000);
		@(negedge clk);
		chk({28'h0, ck_oe, mo_oe, mi_oe, mi_o}, 32'h2);
		$display("test disable done");
		conclude();
	end
	// All tests need well under 20000 cycles.
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude();
	end
endmodule
